// ==== verilog/tag_cmd_defines.svh ====
// Constants for the tag command unit: codes, offsets, field positions, timing.
// Assumes a 250 MHz core clock and framing done outside this block.
`ifndef TAG_CMD_DEFINES_SVH
`define TAG_CMD_DEFINES_SVH
`define CMD_VENDOR_READ   8'ha4
`define CMD_MULTI_READ    8'h23
`define CMD_FAMILY_WRITE  8'h27
`define CMD_FAMILY_LOCK   8'h28
`define CMD_FORMAT_WRITE  8'h29
`define CMD_FORMAT_LOCK   8'h2a
`define REPLY_OK          8'h00
`define REPLY_FAIL        8'h01
`define ERR_BAD_BLOCK     8'h10
`define ERR_LOCKED        8'h12
`define STATUS_OPEN       8'h00
`define STATUS_PROTECTED  8'h01
`define LAST_BLOCK        8'h11
`define ID_BLOCK          5'h10
`define LOCK_BLOCK        5'h11
`define FAMILY_BYTE_POS   0
`define FORMAT_BYTE_POS   1
`define FAMILY_LOCK_POS   0
`define FORMAT_LOCK_POS   1
`define LOCK_VALUE        8'haa
`define FLAG_ADDRESS_BIT  5
`define FLAG_OPTION_BIT   6
`define CRC_PRESET        16'hffff
`define CRC_POLY_REFL     16'h8408
`define CRC_GOOD_RESIDUE  16'hf0b8
`define CLK_MHZ           250
`define PROG_TIME_US      10000
`define PROG_CYCLES       (`PROG_TIME_US * `CLK_MHZ)
`endif

// ==== verilog/tag_cmd_pkg.sv ====
// Types for the tag command unit.
// Assumes the defines header is compiled alongside.
package tag_cmd_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_RECV, ST_CHECK, ST_PROG, ST_SEND, ST_CRC_LO, ST_CRC_HI, ST_DONE
    } cmd_state_t;
    typedef enum logic [1:0] {
        NV_NONE, NV_FAMILY, NV_FORMAT, NV_LOCK
    } nv_op_t;
endpackage : tag_cmd_pkg

// ==== verilog/tag_cmd_unit.sv ====
// Command unit of an RFID memory tag: parses request bytes, serves reads,
// family/format writes and locks, generates and checks the frame CRC.
// Assumes a deframer delivers request bytes with a start and end strobe, and
// a framer takes reply bytes under valid/ready; memory is kept here.
`timescale 1ns/1ps
`include "tag_cmd_defines.svh"
module tag_cmd_unit #(
    parameter int NUM_BLOCKS  = 18,
    parameter int BLOCK_BYTES = 8,
    parameter int PROG_CYCLES = `PROG_CYCLES
) (
    input  wire logic       REF_CLK,
    input  wire logic       RESET_N,
    input  wire logic       RX_START,
    input  wire logic       RX_VALID,
    input  wire logic [7:0] RX_DATA,
    input  wire logic       RX_END,
    input  wire logic       TX_READY,
    output logic            TX_VALID,
    output logic [7:0]      TX_DATA,
    output logic            TX_LAST,
    output logic            BUSY
);
    localparam int RXB = 16;

    logic [7:0]            mem_q [NUM_BLOCKS][BLOCK_BYTES];
    logic [15:0]           wcount_q [NUM_BLOCKS];
    logic [NUM_BLOCKS-1:0] prot_q;
    tag_cmd_pkg::cmd_state_t state_q;
    tag_cmd_pkg::nv_op_t     nv_op_q;
    logic [7:0]  rx_q [RXB];
    logic [4:0]  rx_cnt_q;
    logic [15:0] crc_q;
    logic [7:0]  rsp_q [32];
    logic [5:0]  rsp_len_q;
    logic [5:0]  rsp_idx_q;
    logic [31:0] prog_cnt_q;
    logic [7:0]  nv_val_q;
    logic        tx_valid_q;
    logic [7:0]  tx_data_q;
    logic        tx_last_q;
    logic [15:0] tx_crc_q;
    logic        busy_q;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `CRC_POLY_REFL) : (r >> 1);
        end
        return r;
    endfunction : crc_byte

    function automatic logic [7:0] sec_status(input logic p);
        return p ? `STATUS_PROTECTED : `STATUS_OPEN;
    endfunction : sec_status

    function automatic logic cmd_known(input logic [7:0] c);
        return c == `CMD_VENDOR_READ || c == `CMD_MULTI_READ ||
               c == `CMD_FAMILY_WRITE || c == `CMD_FAMILY_LOCK ||
               c == `CMD_FORMAT_WRITE || c == `CMD_FORMAT_LOCK;
    endfunction : cmd_known

    // Derived fields of the request
    logic        addr_mode;
    logic        opt_flag;
    logic [7:0]  cmd;
    logic [4:0]  par;
    logic        family_locked;
    logic        format_locked;
    assign addr_mode     = rx_q[0][`FLAG_ADDRESS_BIT];
    assign opt_flag      = rx_q[0][`FLAG_OPTION_BIT];
    assign cmd           = rx_q[1];
    assign par           = addr_mode ? 5'd10 : 5'd2;
    assign family_locked = mem_q[`LOCK_BLOCK][`FAMILY_LOCK_POS] == `LOCK_VALUE;
    assign format_locked = mem_q[`LOCK_BLOCK][`FORMAT_LOCK_POS] == `LOCK_VALUE;

    // Request capture and CRC check
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_cnt_q <= 5'd0;
            crc_q    <= `CRC_PRESET;
            for (int i = 0; i < RXB; i++) begin
                rx_q[i] <= 8'h00;
            end
        end else if (state_q == tag_cmd_pkg::ST_IDLE && RX_START) begin
            rx_cnt_q <= 5'd0;
            crc_q    <= `CRC_PRESET;
        end else if (state_q == tag_cmd_pkg::ST_RECV && RX_VALID) begin
            crc_q <= crc_byte(crc_q, RX_DATA);
            if (rx_cnt_q < 5'(RXB)) begin
                rx_q[rx_cnt_q[3:0]] <= RX_DATA;
                rx_cnt_q            <= rx_cnt_q + 5'd1;
            end
        end
    end

    // Command decode, execution, reply build
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        logic [7:0] blk;
        logic [7:0] cnt;
        logic [5:0] n;
        if (!RESET_N) begin
            state_q    <= tag_cmd_pkg::ST_IDLE;
            nv_op_q    <= tag_cmd_pkg::NV_NONE;
            rsp_len_q  <= 6'd0;
            rsp_idx_q  <= 6'd0;
            prog_cnt_q <= 32'd0;
            nv_val_q   <= 8'h00;
            tx_valid_q <= 1'b0;
            tx_data_q  <= 8'h00;
            tx_last_q  <= 1'b0;
            for (int i = 0; i < 32; i++) begin
                rsp_q[i] <= 8'h00;
            end
        end else begin
            blk = 8'h00;
            cnt = 8'h00;
            n   = 6'd0;
            case (state_q)
                tag_cmd_pkg::ST_IDLE: begin
                    if (RX_START) begin
                        state_q <= tag_cmd_pkg::ST_RECV;
                    end
                end
                tag_cmd_pkg::ST_RECV: begin
                    if (RX_END) begin
                        state_q <= tag_cmd_pkg::ST_CHECK;
                    end
                end
                tag_cmd_pkg::ST_CHECK: begin
                    state_q <= tag_cmd_pkg::ST_IDLE;
                    nv_op_q <= tag_cmd_pkg::NV_NONE;
                    rsp_q[0] <= `REPLY_OK;
                    rsp_len_q <= 6'd1;
                    rsp_idx_q <= 6'd0;
                    if (crc_q == `CRC_GOOD_RESIDUE) begin
                        case (cmd)
                            `CMD_VENDOR_READ: begin
                                blk = rx_q[4'(par + 5'd1)];
                                state_q <= tag_cmd_pkg::ST_SEND;
                                if (blk > `LAST_BLOCK) begin
                                    rsp_q[0] <= `REPLY_FAIL;
                                    rsp_q[1] <= `ERR_BAD_BLOCK;
                                    rsp_len_q <= 6'd2;
                                end else begin
                                    n = 6'd1;
                                    if (opt_flag) begin
                                        rsp_q[n[4:0]] <= sec_status(prot_q[blk[4:0]]);
                                        n = n + 6'd1;
                                    end
                                    for (int j = 0; j < BLOCK_BYTES; j++) begin
                                        rsp_q[n[4:0]] <= mem_q[blk[4:0]][j];
                                        n = n + 6'd1;
                                    end
                                    rsp_q[n[4:0]] <= wcount_q[blk[4:0]][7:0];
                                    rsp_q[5'(n + 6'd1)] <= wcount_q[blk[4:0]][15:8];
                                    rsp_len_q <= n + 6'd2;
                                end
                            end
                            `CMD_MULTI_READ: begin
                                blk = rx_q[par[3:0]];
                                cnt = rx_q[4'(par + 5'd1)];
                                state_q <= tag_cmd_pkg::ST_SEND;
                                if (blk > `LAST_BLOCK || cnt > 8'd2 ||
                                    9'(blk) + 9'(cnt) > 9'(`LAST_BLOCK)) begin
                                    rsp_q[0] <= `REPLY_FAIL;
                                    rsp_q[1] <= `ERR_BAD_BLOCK;
                                    rsp_len_q <= 6'd2;
                                end else begin
                                    n = 6'd1;
                                    for (int k = 0; k < 3; k++) begin
                                        if (8'(k) <= cnt) begin
                                            if (opt_flag) begin
                                                rsp_q[n[4:0]] <= sec_status(prot_q[5'(blk + 8'(k))]);
                                                n = n + 6'd1;
                                            end
                                            for (int j = 0; j < BLOCK_BYTES; j++) begin
                                                rsp_q[n[4:0]] <= mem_q[5'(blk + 8'(k))][j];
                                                n = n + 6'd1;
                                            end
                                        end
                                    end
                                    rsp_len_q <= n;
                                end
                            end
                            `CMD_FAMILY_WRITE, `CMD_FORMAT_WRITE: begin
                                if ((cmd == `CMD_FAMILY_WRITE) ? family_locked : format_locked) begin
                                    rsp_q[0] <= `REPLY_FAIL;
                                    rsp_q[1] <= `ERR_LOCKED;
                                    rsp_len_q <= 6'd2;
                                    state_q <= tag_cmd_pkg::ST_SEND;
                                end else begin
                                    nv_op_q <= (cmd == `CMD_FAMILY_WRITE) ? tag_cmd_pkg::NV_FAMILY
                                                                          : tag_cmd_pkg::NV_FORMAT;
                                    nv_val_q <= rx_q[par[3:0]];
                                    prog_cnt_q <= 32'd0;
                                    state_q <= tag_cmd_pkg::ST_PROG;
                                end
                            end
                            `CMD_FAMILY_LOCK, `CMD_FORMAT_LOCK: begin
                                nv_op_q <= tag_cmd_pkg::NV_LOCK;
                                nv_val_q <= (cmd == `CMD_FAMILY_LOCK) ? 8'(`FAMILY_LOCK_POS)
                                                                      : 8'(`FORMAT_LOCK_POS);
                                prog_cnt_q <= 32'd0;
                                state_q <= tag_cmd_pkg::ST_PROG;
                            end
                            default: state_q <= tag_cmd_pkg::ST_IDLE;
                        endcase
                    end
                end
                tag_cmd_pkg::ST_PROG: begin
                    prog_cnt_q <= prog_cnt_q + 32'd1;
                    if (prog_cnt_q >= 32'(PROG_CYCLES - 1)) begin
                        nv_op_q <= tag_cmd_pkg::NV_NONE;
                        state_q <= tag_cmd_pkg::ST_SEND;
                    end
                end
                tag_cmd_pkg::ST_SEND: begin
                    if (!tx_valid_q || TX_READY) begin
                        if (rsp_idx_q < rsp_len_q) begin
                            tx_valid_q <= 1'b1;
                            tx_data_q  <= rsp_q[rsp_idx_q[4:0]];
                            tx_last_q  <= 1'b0;
                            rsp_idx_q  <= rsp_idx_q + 6'd1;
                        end else begin
                            tx_valid_q <= 1'b1;
                            tx_data_q  <= ~tx_crc_q[7:0];
                            state_q    <= tag_cmd_pkg::ST_CRC_HI;
                        end
                    end
                end
                tag_cmd_pkg::ST_CRC_HI: begin
                    if (TX_READY) begin
                        tx_data_q <= ~tx_crc_q[15:8];
                        tx_last_q <= 1'b1;
                        state_q   <= tag_cmd_pkg::ST_DONE;
                    end
                end
                tag_cmd_pkg::ST_DONE: begin
                    if (TX_READY) begin
                        tx_valid_q <= 1'b0;
                        tx_last_q  <= 1'b0;
                        state_q    <= tag_cmd_pkg::ST_IDLE;
                    end
                end
                default: state_q <= tag_cmd_pkg::ST_IDLE;
            endcase
        end
    end

    // Reply CRC, preset per reply frame
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_crc_q <= `CRC_PRESET;
        end else if (state_q == tag_cmd_pkg::ST_CHECK) begin
            tx_crc_q <= `CRC_PRESET;
        end else if (state_q == tag_cmd_pkg::ST_SEND && (!tx_valid_q || TX_READY) && rsp_idx_q < rsp_len_q) begin
            tx_crc_q <= crc_byte(tx_crc_q, rsp_q[rsp_idx_q[4:0]]);
        end
    end

    // Busy flag kept in step with the state register
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            busy_q <= 1'b0;
        end else if (state_q == tag_cmd_pkg::ST_IDLE) begin
            busy_q <= RX_START;
        end else if (state_q == tag_cmd_pkg::ST_CHECK) begin
            busy_q <= crc_q == `CRC_GOOD_RESIDUE && cmd_known(cmd);
        end else if (state_q == tag_cmd_pkg::ST_DONE) begin
            busy_q <= !TX_READY;
        end
    end

    // Nonvolatile array, updated at the end of programming time
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prot_q <= '0;
            for (int b = 0; b < NUM_BLOCKS; b++) begin
                wcount_q[b] <= 16'h0000;
                for (int j = 0; j < BLOCK_BYTES; j++) begin
                    mem_q[b][j] <= 8'h00;
                end
            end
        end else if (state_q == tag_cmd_pkg::ST_PROG && prog_cnt_q >= 32'(PROG_CYCLES - 1)) begin
            case (nv_op_q)
                tag_cmd_pkg::NV_FAMILY: begin
                    mem_q[`ID_BLOCK][`FAMILY_BYTE_POS] <= nv_val_q;
                    wcount_q[`ID_BLOCK] <= wcount_q[`ID_BLOCK] + 16'd1;
                end
                tag_cmd_pkg::NV_FORMAT: begin
                    mem_q[`ID_BLOCK][`FORMAT_BYTE_POS] <= nv_val_q;
                    wcount_q[`ID_BLOCK] <= wcount_q[`ID_BLOCK] + 16'd1;
                end
                tag_cmd_pkg::NV_LOCK: begin
                    mem_q[`LOCK_BLOCK][nv_val_q[2:0]] <= `LOCK_VALUE;
                    wcount_q[`LOCK_BLOCK] <= wcount_q[`LOCK_BLOCK] + 16'd1;
                end
                default: prot_q <= prot_q;
            endcase
        end
    end

    assign TX_VALID = tx_valid_q;
    assign TX_DATA  = tx_data_q;
    assign TX_LAST  = tx_last_q;
    assign BUSY     = busy_q;
endmodule : tag_cmd_unit

// ==== dv/tag_cmd_chk.sv ====
// Checker for the tag command unit reply stream, bound to its top module.
// Assumes one clock domain and replies framed as flags, payload, two CRC bytes.
`timescale 1ns/1ps
module tag_cmd_chk #(
    parameter int PROG_CYCLES = 4
) (
    input wire logic       REF_CLK,
    input wire logic       RESET_N,
    input wire logic       RX_START,
    input wire logic       RX_VALID,
    input wire logic [7:0] RX_DATA,
    input wire logic       RX_END,
    input wire logic       TX_READY,
    input wire logic       TX_VALID,
    input wire logic [7:0] TX_DATA,
    input wire logic       TX_LAST,
    input wire logic       BUSY
);
    localparam int WAIT_MAX = PROG_CYCLES + 60;
    logic [7:0] cnt_q;
    logic       fail_q;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    // Bytes accepted in the current reply
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) cnt_q <= 8'h00;
        else if (!BUSY) cnt_q <= 8'h00;
        else if (TX_VALID && TX_READY) cnt_q <= cnt_q + 8'h01;
    end
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) fail_q <= 1'b0;
        else if (!BUSY) fail_q <= 1'b0;
        else if (TX_VALID && TX_READY && cnt_q == 8'h00) fail_q <= (TX_DATA == 8'h01);
    end
    tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
        else $error("reply byte changed while not accepted");
    idle_quiet_a: assert property (!BUSY |-> !TX_VALID)
        else $error("reply byte while idle");
    reply_flag_a: assert property (TX_VALID && cnt_q == 8'h00 |-> TX_DATA == 8'h00 || TX_DATA == 8'h01)
        else $error("bad reply flags byte");
    fail_len_a: assert property (TX_VALID && TX_LAST && fail_q |-> cnt_q == 8'h03)
        else $error("failure reply length wrong");
    fail_code_a: assert property (TX_VALID && fail_q && cnt_q == 8'h01 |-> TX_DATA == 8'h10 || TX_DATA == 8'h12)
        else $error("unexpected failure code");
    last_pair_a: assert property (TX_LAST |-> TX_VALID && cnt_q >= 8'h02)
        else $error("last byte without flags and CRC");
    no_early_a: assert property (RX_END |=> !TX_VALID [*2])
        else $error("reply too early after frame end");
    answer_bound_a: assert property (RX_END |-> ##[1:WAIT_MAX] (TX_VALID || !BUSY))
        else $error("no answer or return to idle");
    end_free_a: assert property (TX_VALID && TX_READY && TX_LAST |-> ##[1:3] !BUSY)
        else $error("unit stays busy after last byte");
    start_take_a: assert property (RX_START && !BUSY |=> BUSY)
        else $error("frame start not taken");
endmodule : tag_cmd_chk
bind tag_cmd_unit tag_cmd_chk #(.PROG_CYCLES(PROG_CYCLES)) chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
    .RX_START(RX_START), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_END(RX_END), .TX_READY(TX_READY),
    .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .BUSY(BUSY));

// ==== dv/reader_model.sv ====
// Reader side model: sends request frames with CRC, collects reply bytes.
// Assumes the bench calls its tasks; inputs change at the falling edge.
`timescale 1ns/1ps
module reader_model (
    input wire logic       clk,
    output logic           start,
    output logic           valid,
    output logic [7:0]     data,
    output logic           rx_end,
    output logic           ready,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_last
);
    initial begin
        start  = 1'b0;
        valid  = 1'b0;
        data   = 8'h00;
        rx_end = 1'b0;
        ready  = 1'b0;
    end
    // Inverted CRC, preset all ones, reflected x16+x12+x5+1
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c ^= {8'h00, b[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
        end
        return ~c;
    endfunction : crc16
    task automatic send(input logic [7:0] b[$], input logic bad);
        logic [15:0] c;
        c = crc16(b) ^ {15'h0000, bad};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        @(negedge clk);
        start = 1;
        foreach (b[i]) begin
            @(negedge clk);
            start = 0;
            valid = 1;
            data = b[i];
        end
        @(negedge clk);
        valid = 0;
        data = ~data;
        rx_end = 1;
        @(negedge clk);
        rx_end = 0;
    endtask : send
    // Slow mode accepts a byte only every other cycle
    task automatic recv(output logic [7:0] r[$], output logic got, input logic slow, input int limit);
        r = {};
        got = 0;
        for (int n = 0; n < limit && !got; n++) begin
            @(negedge clk);
            ready = slow ? !ready : 1'b1;
            @(posedge clk);
            if (tx_valid === 1'b1 && ready) begin
                r.push_back(tx_data);
                got = (tx_last === 1'b1);
            end
        end
        @(negedge clk);
        ready = 0;
    endtask : recv
endmodule : reader_model

// ==== dv/tb.sv ====
// Self-checking bench for the tag command unit with a reader model.
// Assumes a shortened programming time and all memory clear after reset.
`timescale 1ns/1ps
module tb;
    typedef logic [7:0] bytes_t[$];
    localparam logic [7:0] MAKER = 8'h5e; // Arbitrary maker code
    logic       REF_CLK, RESET_N, RX_START, RX_VALID, RX_END, TX_READY, TX_VALID, TX_LAST, BUSY;
    logic [7:0] RX_DATA, TX_DATA;
    int         fail_count, checked;
    tag_cmd_unit #(.PROG_CYCLES(4)) DUT (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .RX_START(RX_START),
        .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_END(RX_END), .TX_READY(TX_READY),
        .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .BUSY(BUSY));
    reader_model rdr (.clk(REF_CLK), .start(RX_START), .valid(RX_VALID), .data(RX_DATA), .rx_end(RX_END),
        .ready(TX_READY), .tx_valid(TX_VALID), .tx_data(TX_DATA), .tx_last(TX_LAST));
    initial begin
        REF_CLK = 0;
        forever #2 REF_CLK = ~REF_CLK;
    end
    function automatic bytes_t z(input int n);
        bytes_t q;
        repeat (n) q.push_back(8'h00);
        return q;
    endfunction : z
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t reply byte %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic idle;
        for (int n = 0; n < 50 && BUSY !== 1'b0; n++) @(negedge REF_CLK);
        check({7'h00, BUSY}, 8'h00);
        if (BUSY !== 1'b0) report_and_stop();
    endtask : idle
    // One request and its full reply, CRC included
    task automatic xact(input bytes_t req, input bytes_t exp, input logic slow);
        bytes_t      r;
        logic        got;
        logic [15:0] c;
        rdr.send(req, 1'b0);
        rdr.recv(r, got, slow, 3000);
        if (!got) begin
            fail_count++;
            $display("ERROR %0t no reply", $time);
            report_and_stop();
        end else begin
            c = rdr.crc16(exp);
            exp.push_back(c[7:0]);
            exp.push_back(c[15:8]);
            check(8'(r.size()), 8'(exp.size()));
            foreach (exp[i]) check(r[i], exp[i]);
            idle();
        end
    endtask : xact
    task automatic silent(input bytes_t req, input logic bad);
        bytes_t r;
        logic   got;
        rdr.send(req, bad);
        rdr.recv(r, got, 1'b0, 40);
        check({7'h00, got}, 8'h00);
        idle();
    endtask : silent
    task automatic s_vendor;
        xact('{8'h00, 8'ha4, MAKER, 8'h00}, {8'h00, z(10)}, 0);
        xact('{8'h40, 8'ha4, MAKER, 8'h03}, {8'h00, z(11)}, 1);
        xact('{8'h00, 8'ha4, MAKER, 8'h11}, {8'h00, z(10)}, 1);
        xact('{8'h00, 8'ha4, MAKER, 8'h12}, '{8'h01, 8'h10}, 0);
    endtask : s_vendor
    task automatic s_multi;
        xact('{8'h00, 8'h23, 8'h00, 8'h02}, {8'h00, z(24)}, 0);
        xact('{8'h40, 8'h23, 8'h10, 8'h01}, {8'h00, z(18)}, 1);
        xact('{8'h00, 8'h23, 8'h11, 8'h00}, {8'h00, z(8)}, 0);
        xact('{8'h00, 8'h23, 8'h11, 8'h01}, '{8'h01, 8'h10}, 0);
        xact('{8'h00, 8'h23, 8'h12, 8'h00}, '{8'h01, 8'h10}, 0);
    endtask : s_multi
    task automatic s_ident;
        xact('{8'h00, 8'h27, 8'h5a}, '{8'h00}, 1);
        xact('{8'h00, 8'h29, 8'h3c}, '{8'h00}, 0);
        xact('{8'h00, 8'h23, 8'h10, 8'h00}, {8'h00, 8'h5a, 8'h3c, z(6)}, 0);
        xact('{8'h00, 8'h2a}, '{8'h00}, 0);
        xact('{8'h00, 8'h29, 8'h77}, '{8'h01, 8'h12}, 0);
        xact('{8'h00, 8'h28}, '{8'h00}, 0);
        xact('{8'h00, 8'h27, 8'h66}, '{8'h01, 8'h12}, 1);
        xact('{8'h00, 8'h23, 8'h10, 8'h01}, {8'h00, 8'h5a, 8'h3c, z(6), 8'haa, 8'haa, z(6)}, 0);
        xact({8'h00, 8'ha4, MAKER, 8'h10}, {8'h00, 8'h5a, 8'h3c, z(6), 8'h02, 8'h00}, 0);
        xact({8'h60, 8'ha4, MAKER, z(8), 8'h11}, {8'h00, 8'h00, 8'haa, 8'haa, z(6), 8'h02, 8'h00}, 1);
        xact({8'h20, 8'h23, z(8), 8'h10, 8'h00}, {8'h00, 8'h5a, 8'h3c, z(6)}, 0);
    endtask : s_ident
    task automatic s_refuse;
        silent('{8'h00, 8'h55, 8'h00}, 1'b0);
        silent('{8'h00, 8'ha4, MAKER, 8'h00}, 1'b1);
        xact('{8'h00, 8'ha4, MAKER, 8'h00}, {8'h00, z(10)}, 0);
    endtask : s_refuse
    initial begin
        fail_count = 0;
        checked = 0;
        RESET_N = 0;
        repeat (8) @(negedge REF_CLK);
        RESET_N = 1;
        check({7'h00, BUSY}, 8'h00);
        s_vendor();
        s_multi();
        s_refuse();
        s_ident();
        report_and_stop();
    end
endmodule : tb
